// file: logic/rf_frontend_debug_observer.sv
`timescale 1ns/1ps
module rf_frontend_debug_observer
    import rf_obs_pkg::*;
(
    // Clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst_n,
    // Front-end samples
    input  wire logic               i_sample_strobe,
    input  wire logic [RAW_W-1:0]   i_raw_inphase,
    input  wire logic [RAW_W-1:0]   i_raw_quadrature,
    input  wire logic [PROC_W-1:0]  i_filtered_inphase_data,
    input  wire logic [PROC_W-1:0]  i_filtered_quadrature_data,
    input  wire logic [PROC_W-1:0]  i_matched_filter_first_out,
    input  wire logic [PROC_W-1:0]  i_matched_filter_second_out,
    input  wire logic [PROC_W-1:0]  i_sync_filter_out,
    // Front-end activity
    input  wire logic               i_tx_sending,
    input  wire logic               i_rx_ongoing,
    input  wire logic               i_collision_detect,
    // AXI4-Lite write
    input  wire logic               i_awvalid,
    output logic                    o_awready,
    input  wire logic [7:0]         i_awaddr,
    input  wire logic               i_wvalid,
    output logic                    o_wready,
    input  wire logic [31:0]        i_wdata,
    input  wire logic [3:0]         i_wstrb,
    output logic                    o_bvalid,
    input  wire logic               i_bready,
    output logic [1:0]              o_bresp,
    // AXI4-Lite read
    input  wire logic               i_arvalid,
    output logic                    o_arready,
    input  wire logic [7:0]         i_araddr,
    output logic                    o_rvalid,
    input  wire logic               i_rready,
    output logic [31:0]             o_rdata,
    output logic [1:0]              o_rresp,
    // Debug outputs
    output logic [DAC_W-1:0]        o_aux_output_one,
    output logic [DAC_W-1:0]        o_aux_output_two,
    output logic                    o_tx_active_trig,
    output logic                    o_rx_enable_trig,
    output logic                    o_collision_pulse,
    output logic                    o_irq
);

    // ------------------------------------------------------------------
    // Capture of observation points
    // ------------------------------------------------------------------
    obs_points_if pts ();

    logic [PROC_CH-1:0][PROC_W-1:0] proc_vals;
    assign proc_vals = {i_sync_filter_out, i_matched_filter_second_out,
                        i_matched_filter_first_out, i_filtered_quadrature_data,
                        i_filtered_inphase_data};

    obs_capture u_capture (
        .i_sys_clk        (i_sys_clk),
        .i_rst_n          (i_rst_n),
        .i_sample_strobe  (i_sample_strobe),
        .i_raw_inphase    (i_raw_inphase),
        .i_raw_quadrature (i_raw_quadrature),
        .i_proc_vals      (proc_vals),
        .pts              (pts.producer)
    );

    // ------------------------------------------------------------------
    // Trigger outputs
    // ------------------------------------------------------------------
    logic collision_prev;

    // Activity levels follow the front end one cycle later
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_active_trig <= 1'b0;
            o_rx_enable_trig <= 1'b0;
        end else begin
            o_tx_active_trig <= i_tx_sending;
            o_rx_enable_trig <= i_rx_ongoing;
        end
    end

    // One pulse per rising edge of collision detect
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            collision_prev    <= 1'b0;
            o_collision_pulse <= 1'b0;
        end else begin
            collision_prev    <= i_collision_detect;
            o_collision_pulse <= i_collision_detect && !collision_prev;
        end
    end

    // ------------------------------------------------------------------
    // Control, status and mask registers
    // ------------------------------------------------------------------
    logic [2:0]      sel_one_bits;
    logic [2:0]      sel_two_bits;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] status_clr;
    logic            wr_fire;
    logic            rd_fire;
    logic [7:0]      aw_addr_q;
    logic [31:0]     w_data_q;
    logic [3:0]      w_strb_q;
    logic            aw_held;
    logic            w_held;

    // Activity edges seen against the registered trigger levels; collision edge seen against collision_prev
    assign events[EV_TX_END]    = o_tx_active_trig && !i_tx_sending;
    assign events[EV_RX_START]  = !o_rx_enable_trig && i_rx_ongoing;
    assign events[EV_RX_END]    = o_rx_enable_trig && !i_rx_ongoing;
    assign events[EV_COLLISION] = i_collision_detect && !collision_prev;

    assign wr_fire    = aw_held && w_held && !o_bvalid;
    assign rd_fire    = i_arvalid && o_arready;
    assign status_clr = (rd_fire && i_araddr[7:2] == ADDR_STATUS[7:2]) ? '1 : '0;

    // Selection command written by the host
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_one_bits <= SEL_RAW;
            sel_two_bits <= SEL_RAW;
            mask         <= MASK_RESET;
        end else if (wr_fire && w_strb_q[0] && aw_addr_q[1:0] == 2'h0) begin
            if (aw_addr_q[7:2] == ADDR_CTRL[7:2]) begin
                sel_one_bits <= w_data_q[CTRL_SEL_ONE_LSB +: 3];
                sel_two_bits <= w_data_q[CTRL_SEL_TWO_LSB +: 3];
            end
            if (aw_addr_q[7:2] == ADDR_MASK[7:2]) begin
                mask <= w_data_q[EV_W-1:0];
            end
        end
    end

    // Sticky events, read clears, a new event wins over the clear
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= '0;
            o_irq  <= 1'b0;
        end else begin
            status <= (status & ~status_clr) | events;
            o_irq  <= |(status & mask);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data taken in either order, response after both
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_held    <= 1'b1;
                w_data_q  <= i_wdata;
                w_strb_q  <= i_wstrb;
                o_wready  <= 1'b0;
            end
            if (wr_fire) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= (aw_addr_q > ADDR_LAST || aw_addr_q[1:0] != 2'h0) ?
                            RESP_SLVERR : RESP_OKAY;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_bad;
    logic [5:0]  rd_idx;

    // Read data decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_bad  = 1'b0;
        rd_idx  = i_araddr[7:2];
        if (i_araddr[1:0] != 2'h0 || i_araddr > ADDR_LAST) begin
            rd_bad = 1'b1;
        end else if (rd_idx == ADDR_CTRL[7:2]) begin
            rd_word = {25'h0, sel_two_bits, 1'b0, sel_one_bits};
        end else if (rd_idx == ADDR_STATUS[7:2]) begin
            rd_word = {28'h0, status};
        end else if (rd_idx == ADDR_MASK[7:2]) begin
            rd_word = {28'h0, mask};
        end else if (rd_idx == ADDR_LIVE[7:2]) begin
            rd_word = {29'h0, o_collision_pulse, o_rx_enable_trig, o_tx_active_trig};
        end else if (rd_idx < ADDR_PROC0[7:2]) begin
            rd_word = {24'h0, pts.raw_pt[2'(rd_idx - ADDR_RAW0[7:2])]};
        end else begin
            rd_word = {24'h0, pts.proc_pt[4'(rd_idx - ADDR_PROC0[7:2])]};
        end
    end

    // One read at a time, answer the cycle after the address
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end else if (rd_fire) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= rd_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Aux converter codes
    // ------------------------------------------------------------------
    obs_sel_t sel_one;
    obs_sel_t sel_two;
    assign sel_one = obs_sel_t'(sel_one_bits);
    assign sel_two = obs_sel_t'(sel_two_bits);

    // Top eight bits of a 15-bit point pair, offset binary
    function automatic logic [7:0] proc_code(input logic [7:0] hi, input logic [7:0] lo);
        return {~hi[6], hi[5:0], lo[7]};
    endfunction

    // Map a selection onto a converter code; raw choice fixed per output
    function automatic logic [7:0] aux_code(input obs_sel_t sel, input logic [7:0] raw_hi);
        logic [7:0] code;
        code = DAC_MID;
        unique case (sel)
            SEL_RAW:       code = {~raw_hi[7], raw_hi[6:0]};
            SEL_FILT_I:    code = proc_code(pts.proc_pt[0], pts.proc_pt[1]);
            SEL_FILT_Q:    code = proc_code(pts.proc_pt[2], pts.proc_pt[3]);
            SEL_MF_FIRST:  code = proc_code(pts.proc_pt[4], pts.proc_pt[5]);
            SEL_MF_SECOND: code = proc_code(pts.proc_pt[6], pts.proc_pt[7]);
            SEL_SYNC:      code = proc_code(pts.proc_pt[8], pts.proc_pt[9]);
            default:       code = DAC_MID;
        endcase
        return code;
    endfunction

    // Codes change only when points or selection change
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_aux_output_one <= DAC_MID;
            o_aux_output_two <= DAC_MID;
        end else begin
            o_aux_output_one <= aux_code(sel_one, pts.raw_pt[2]);
            o_aux_output_two <= aux_code(sel_two, pts.raw_pt[0]);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_quiet;
        !i_sample_strobe ##1 $stable(sel_one_bits) && $stable(sel_two_bits);
    endsequence
    sequence s_sync_sample;
        i_sample_strobe && sel_one == SEL_SYNC ##1 $stable(sel_one_bits);
    endsequence

    AST_TX_LEVEL: assert property (o_tx_active_trig == $past(i_tx_sending))
        else $error("tx trigger not following transmission");
    AST_RX_LEVEL: assert property ($rose(i_rx_ongoing) |=> o_rx_enable_trig
        ##0 status[EV_RX_START])
        else $error("rx trigger start not marked");
    AST_COLL_CAUSE: assert property ($rose(i_collision_detect) |=> o_collision_pulse)
        else $error("collision pulse missing");
    AST_COLL_SINGLE: assert property (o_collision_pulse |=> !o_collision_pulse)
        else $error("collision pulse longer than one cycle");
    AST_RAW_ONE_Q: assert property ($past(sel_one) == SEL_RAW |->
        o_aux_output_one == {~$past(pts.raw_pt[2][7]), $past(pts.raw_pt[2][6:0])})
        else $error("aux one not carrying quadrature");
    AST_RAW_TWO_I: assert property ($past(sel_two) == SEL_RAW |->
        o_aux_output_two == {~$past(pts.raw_pt[0][7]), $past(pts.raw_pt[0][6:0])})
        else $error("aux two not carrying in-phase");
    AST_SYNC_CODE: assert property (s_sync_sample |=> o_aux_output_one ==
        {~$past(i_sync_filter_out[14], 2), $past(i_sync_filter_out[13:7], 2)})
        else $error("aux code not top eight bits");
    AST_AUX_HOLD: assert property (s_quiet |=> $stable(o_aux_output_one)
        && $stable(o_aux_output_two))
        else $error("aux output moved between samples");
    AST_WR_RESP: assert property (wr_fire |=> o_bvalid)
        else $error("write not answered");

endmodule

// file: logic/rf_obs_pkg.sv
// Summary of operation
// - Raw in-phase 10-bit sample observable, sign at bit 9, split over two points.
// - Raw quadrature 10-bit sample observable, sign at bit 9, split over two points.
// - Filtered in-phase 15-bit value: bits 14:8 on one point, 7:0 on another.
// - Filtered quadrature 15-bit value split into bits 14:8 and 7:0.
// - First matched-filter output, 15-bit signed, split high and low.
// - Second matched-filter output split high and low; meaningless for type A 106k.
// - Synchronisation filter output, 15-bit signed, split high and low.
// - Transmit trigger is high for exactly the cycles data is being sent, one cycle later.
// - Receive trigger high while reception runs; edges mark start and end.
// - One single high pulse on the collision trigger per detected collision.
// - Each selected value leaves as an eight-bit converter code.
// - Raw samples: quadrature always on aux one, in-phase always on aux two.
package rf_obs_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RAW_W        = 10;
    localparam int PROC_W       = 15;
    localparam int PROC_CH      = 5;
    localparam int RAW_PTS      = 4;
    localparam int PROC_PTS     = 10;
    localparam int DAC_W        = 8;
    localparam int EV_W         = 4;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_MASK    = 8'h08;
    localparam logic [7:0] ADDR_LIVE    = 8'h0C;
    localparam logic [7:0] ADDR_RAW0    = 8'h10;
    localparam logic [7:0] ADDR_PROC0   = 8'h20;
    localparam logic [7:0] ADDR_LAST    = 8'h44;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_SEL_ONE_LSB     = 0;
    localparam int CTRL_SEL_TWO_LSB     = 4;
    localparam int EV_TX_END            = 0;
    localparam int EV_RX_START          = 1;
    localparam int EV_RX_END            = 2;
    localparam int EV_COLLISION         = 3;
    localparam logic [3:0] MASK_RESET   = 4'h0;
    localparam logic [7:0] DAC_MID      = 8'h80;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------------
    // Aux output selection
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_RAW       = 3'b000,
        SEL_FILT_I    = 3'b001,
        SEL_FILT_Q    = 3'b010,
        SEL_MF_FIRST  = 3'b011,
        SEL_MF_SECOND = 3'b100,
        SEL_SYNC      = 3'b101
    } obs_sel_t;

endpackage

// file: logic/obs_points_if.sv
`timescale 1ns/1ps
// Captured observation points passed from capture to top
interface obs_points_if;
    import rf_obs_pkg::*;
    logic [RAW_PTS-1:0][7:0]  raw_pt;
    logic [PROC_PTS-1:0][7:0] proc_pt;
    modport producer (output raw_pt, output proc_pt);
    modport consumer (input raw_pt, input proc_pt);
endinterface

// file: logic/obs_capture.sv
`timescale 1ns/1ps
module obs_capture
    import rf_obs_pkg::*;
(
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    // Samples
    input  wire logic                          i_sample_strobe,
    input  wire logic [RAW_W-1:0]              i_raw_inphase,
    input  wire logic [RAW_W-1:0]              i_raw_quadrature,
    input  wire logic [PROC_CH-1:0][PROC_W-1:0] i_proc_vals,
    // Points
    obs_points_if.producer                     pts
);

    // ------------------------------------------------------------------
    // Raw converter samples
    // ------------------------------------------------------------------
    // Upper byte, then sign with low seven bits
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pts.raw_pt <= '0;
        end else if (i_sample_strobe) begin
            pts.raw_pt[0] <= i_raw_inphase[9:2];
            pts.raw_pt[1] <= {i_raw_inphase[9], i_raw_inphase[6:0]};
            pts.raw_pt[2] <= i_raw_quadrature[9:2];
            pts.raw_pt[3] <= {i_raw_quadrature[9], i_raw_quadrature[6:0]};
        end
    end

    // ------------------------------------------------------------------
    // Processed values, high point then low point per channel
    // ------------------------------------------------------------------
    for (genvar k = 0; k < PROC_CH; k++) begin : g_proc
        // Top bit of the high point reads zero
        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                pts.proc_pt[2*k]   <= '0;
                pts.proc_pt[2*k+1] <= '0;
            end else if (i_sample_strobe) begin
                pts.proc_pt[2*k]   <= {1'b0, i_proc_vals[k][14:8]};
                pts.proc_pt[2*k+1] <= i_proc_vals[k][7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    AST_RAW_I: assert property (i_sample_strobe |=>
        pts.raw_pt[0] == $past(i_raw_inphase[9:2])
        && pts.raw_pt[1] == {$past(i_raw_inphase[9]), $past(i_raw_inphase[6:0])})
        else $error("raw in-phase point wrong");
    AST_RAW_Q: assert property (i_sample_strobe |=>
        pts.raw_pt[2] == $past(i_raw_quadrature[9:2])
        && pts.raw_pt[3] == {$past(i_raw_quadrature[9]), $past(i_raw_quadrature[6:0])})
        else $error("raw quadrature point wrong");
    AST_FILT_I: assert property (i_sample_strobe |=>
        {pts.proc_pt[0][6:0], pts.proc_pt[1]} == $past(i_proc_vals[0]))
        else $error("filtered in-phase points wrong");
    AST_FILT_Q: assert property (i_sample_strobe |=>
        {pts.proc_pt[2][6:0], pts.proc_pt[3]} == $past(i_proc_vals[1]))
        else $error("filtered quadrature points wrong");
    AST_MF_FIRST: assert property (i_sample_strobe |=>
        {pts.proc_pt[4][6:0], pts.proc_pt[5]} == $past(i_proc_vals[2]))
        else $error("first matched filter points wrong");
    AST_MF_SECOND: assert property (i_sample_strobe |=>
        {pts.proc_pt[6][6:0], pts.proc_pt[7]} == $past(i_proc_vals[3]))
        else $error("second matched filter points wrong");
    AST_SYNC: assert property (i_sample_strobe |=>
        {pts.proc_pt[8], pts.proc_pt[9]} == {1'b0, $past(i_proc_vals[4])})
        else $error("sync filter points wrong");
    AST_HOLD_PT: assert property (!i_sample_strobe |=> $stable(pts.proc_pt))
        else $error("points moved without a sample");

endmodule

// file: test/scope_model.sv
`timescale 1ns/1ps
module scope_model (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // Observed triggers
    input  wire logic i_tx_trig,
    input  wire logic i_coll,
    // Tallies
    output int        o_tx_ends,
    output int        o_coll_count
);
    logic tx_last;
    // Count tx trigger falling edges and collision trigger high cycles as a scope would
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_last <= 1'b0;
            o_tx_ends <= 0;
            o_coll_count <= 0;
        end else begin
            tx_last <= i_tx_trig;
            if (tx_last && !i_tx_trig) o_tx_ends <= o_tx_ends + 1;
            if (i_coll) o_coll_count <= o_coll_count + 1;
        end
    end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    import rf_obs_pkg::*;
    logic i_sys_clk = 0, i_rst_n = 0, i_sample_strobe, i_tx_sending, i_rx_ongoing;
    logic i_collision_detect, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic o_tx_active_trig, o_rx_enable_trig, o_collision_pulse;
    logic [RAW_W-1:0] i_raw_inphase, i_raw_quadrature;
    logic [PROC_W-1:0] i_filtered_inphase_data, i_filtered_quadrature_data, i_sync_filter_out;
    logic [PROC_W-1:0] i_matched_filter_first_out, i_matched_filter_second_out;
    logic [7:0] i_awaddr, i_araddr, o_aux_output_one, o_aux_output_two;
    logic [31:0] i_wdata, o_rdata, rd;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, resp;
    int bad_count, checked, tx_ends, coll_count;
    // Ctrl byte, expected aux one, expected aux two
    localparam logic [23:0] ROWS [7] = '{24'h00FF01, 24'h217F00, 24'h320081, 24'h4381BE,
                                         24'h54BE7E, 24'h657E80, 24'h17807F};
    // Address, expected word
    localparam logic [39:0] REGS [7] = '{40'h1400000084, 40'h1C0000007C, 40'h200000007F,
        40'h24000000FF, 40'h380000001F, 40'h4400000000, 40'h4800000000};

    always #2.5 i_sys_clk = ~i_sys_clk;
    rf_frontend_debug_observer i_rf_frontend_debug_observer (.*);
    scope_model i_scope_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_tx_trig(o_tx_active_trig), .i_coll(o_collision_pulse),
        .o_tx_ends(tx_ends), .o_coll_count(coll_count));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= d;
        i_bready <= 1'b1;
        while (!o_bvalid) begin
            @(posedge i_sys_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end
        resp = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        while (!o_rvalid) begin
            @(posedge i_sys_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end
        rd = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask
    task automatic sample();
        @(posedge i_sys_clk);
        i_sample_strobe <= 1'b1;
        @(posedge i_sys_clk);
        i_sample_strobe <= 1'b0;
        cyc(3);
    endtask
    task automatic complete_run();
        $display("counts checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    // Hang guard
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    initial begin
        {i_sample_strobe, i_tx_sending, i_rx_ongoing, i_collision_detect} = 4'h0;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0000000000000F;
        i_raw_inphase = 10'h204;
        i_raw_quadrature = 10'h1FC;
        i_filtered_inphase_data = 15'h7FFF;
        i_filtered_quadrature_data = 15'h4000;
        i_matched_filter_first_out = 15'h0080;
        i_matched_filter_second_out = 15'h1F00;
        i_sync_filter_out = 15'h7F00;
        cyc(5);
        i_rst_n <= 1'b1;
        cyc(1);
        chk("aux one reset", DAC_MID, o_aux_output_one);
        axr(ADDR_MASK);
        chk("mask reset", MASK_RESET, rd);
        sample();
        foreach (ROWS[k]) begin
            axw(ADDR_CTRL, ROWS[k][23:16]);
            chk("wresp", RESP_OKAY, resp);
            cyc(2);
            chk("aux one", ROWS[k][15:8], o_aux_output_one);
            chk("aux two", ROWS[k][7:0], o_aux_output_two);
        end
        foreach (REGS[k]) begin
            axr(REGS[k][39:32]);
            chk("point", REGS[k][31:0], rd);
            chk("resp", (k == 6) ? RESP_SLVERR : RESP_OKAY, resp);
        end
        $display("test selection done");
        axw(ADDR_CTRL, 32'h0);
        i_raw_quadrature <= 10'h000;
        cyc(4);
        chk("hold", 32'hFF, o_aux_output_one);
        sample();
        chk("update", 32'h80, o_aux_output_one);
        axw(ADDR_MASK, 32'hF);
        i_tx_sending <= 1'b1;
        cyc(2);
        chk("tx trig", 1'b1, o_tx_active_trig);
        axr(ADDR_LIVE);
        chk("live", 32'h1, rd);
        i_tx_sending <= 1'b0;
        i_rx_ongoing <= 1'b1;
        cyc(2);
        chk("rx trig", 1'b1, o_rx_enable_trig);
        chk("tx trig low", 1'b0, o_tx_active_trig);
        i_rx_ongoing <= 1'b0;
        i_collision_detect <= 1'b1;
        cyc(4);
        i_collision_detect <= 1'b0;
        cyc(3);
        chk("tx ends", 1, tx_ends);
        chk("collisions", 1, coll_count);
        chk("irq", 1'b1, o_irq);
        axr(ADDR_STATUS);
        chk("status", 32'hF, rd);
        axr(ADDR_STATUS);
        chk("status cleared", 32'h0, rd);
        axw(ADDR_MASK, 32'h0);
        i_tx_sending <= 1'b1;
        cyc(2);
        i_tx_sending <= 1'b0;
        cyc(4);
        chk("irq masked", 1'b0, o_irq);
        $display("test events done");
        i_rst_n <= 1'b0;
        cyc(2);
        chk("aux two in reset", DAC_MID, o_aux_output_two);
        chk("irq in reset", 1'b0, o_irq);
        i_rst_n <= 1'b1;
        axw(8'h01, 32'h0000_0005);
        chk("bad write resp", RESP_SLVERR, resp);
        axr(ADDR_CTRL);
        chk("ctrl kept", 32'h0, rd);
        axr(ADDR_STATUS);
        chk("status after reset", 32'h0, rd);
        axw(ADDR_CTRL, 32'h0000_0005);
        sample();
        chk("sync code", 32'h7E, o_aux_output_one);
        $display("test reset done");
        complete_run();
    end
endmodule
